// *** design/metering_peak_status_regs.sv ***
// What this block does
// R1 - filter disable word of zero keeps every high-pass filter running.
// R2 - any nonzero filter disable word bypasses all high-pass filters together.
// R3 - current peak register low 24 bits hold the current channel peak.
// R4 - current peak bits 24 to 26 tag phase A, B or C.
// R5 - voltage peak register low 24 bits hold the voltage channel peak.
// R6 - voltage peak bits 24 to 26 tag phase A, B or C.
// R7 - bits 31 to 27 of both peak registers always read zero.
// R8 - 24 or 20 bit zero-padded registers go out as 32 bits, upper zeros.
// R9 - 24 bit sign-extended registers go out as 32 bits, sign replicated.
// R10 - 10 bit unsigned registers go out as 16 bits, top six zero.
// R11 - event bits 0 and 1 flag bit 30 changes in active energies.
// R12 - event bits 2 to 4 flag bit 30 changes in reactive/apparent energies.
// R13 - event bit 5 flags end of a line cycle integration.
// R14 - event bits 6 to 8 flag active sign changes, signs in bits 0-2.
// R15 - event bit 9 flags pulse one sum sign change, sign in bit 3.
// R16 - event bits 10, 11 flag reactive sign changes, signs in bits 4-5.
// R17 - eight bit register sets peak detection length in half line cycles.
// R18 - event flags stay set until software writes one to them.
module metering_peak_status_regs #(
   parameter int DATA_W = 24
) (
   // clock and reset
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // register port
   input  wire logic [15:0]             regAddr,
   input  wire logic                    regWrite,
   input  wire logic                    regRead,
   input  wire logic [31:0]             regWriteData,
   output logic      [31:0]             readData,
   output logic      [5:0]              readBits,
   output logic                         readHit,
   output logic                         readValid,
   // registers held elsewhere in the bank
   input  wire logic                    extHit,
   input  wire logic [31:0]             extValue,
   input  wire metering_pkg::word_fmt_t extFormat,
   // filter control
   output logic                         highpassBypass,
   // peak detection samples
   input  wire logic                    sampleValid,
   input  wire logic                    halfCycle,
   input  wire logic [2:0][DATA_W-1:0]  currentMag,
   input  wire logic [2:0][DATA_W-1:0]  voltageMag,
   // energy accumulator bit 30, per type and phase
   input  wire logic [4:0][2:0]         accumBit30,
   input  wire logic                    lineCycleMode,
   input  wire logic                    lineCycleDone,
   // power signs
   input  wire logic [2:0]              activeSignTotal,
   input  wire logic [2:0]              activeSignFund,
   input  wire logic [1:0]              reactiveSignTotal,
   input  wire logic [1:0]              reactiveSignFund,
   input  wire logic                    pulse1SumSign,
   // event flags
   output logic      [11:0]             eventFlags
);

   logic [23:0] hpfWord;
   logic [7:0]  accumMode;
   logic [7:0]  peakWindow;
   logic [14:0] prevBit30;
   logic [5:0]  prevSign;
   logic        primed;
   logic [11:0] next_eventFlags;

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire hitHpf    = regAddr == metering_pkg::ADDR_HPF_DISABLE;
   wire hitCur    = regAddr == metering_pkg::ADDR_CURRENT_PEAK;
   wire hitVolt   = regAddr == metering_pkg::ADDR_VOLTAGE_PEAK;
   wire hitStatus = regAddr == metering_pkg::ADDR_EVENT_FLAGS;
   wire hitSign   = regAddr == metering_pkg::ADDR_POWER_SIGN;
   wire hitMode   = regAddr == metering_pkg::ADDR_ACCUM_MODE;
   wire hitWindow = regAddr == metering_pkg::ADDR_PEAK_WINDOW;
   wire localHit  = hitHpf | hitCur | hitVolt | hitStatus | hitSign | hitMode | hitWindow;
   wire anyHit    = localHit | extHit;

   // ----------------------------------------
   // peak capture units
   // ----------------------------------------
   peak_if #(.W(DATA_W)) curLink ();
   peak_if #(.W(DATA_W)) voltLink ();

   assign curLink.sampleValid  = sampleValid;
   assign curLink.mag          = currentMag;
   assign curLink.halfCycle    = halfCycle;
   assign curLink.windowCycles = peakWindow;
   assign voltLink.sampleValid  = sampleValid;
   assign voltLink.mag          = voltageMag;
   assign voltLink.halfCycle    = halfCycle;
   assign voltLink.windowCycles = peakWindow;

   peak_capture_unit #(.W(DATA_W)) currentPeak (
      .clk  (clk),
      .rstn (rstn),
      .link (curLink)
   );

   peak_capture_unit #(.W(DATA_W)) voltagePeak (
      .clk  (clk),
      .rstn (rstn),
      .link (voltLink)
   );

   // top five bits stay zero by construction [R7]
   wire [31:0] curPeakWord  = {5'h00, curLink.tag, curLink.value[23:0]};   // [R3] [R4]
   wire [31:0] voltPeakWord = {5'h00, voltLink.tag, voltLink.value[23:0]}; // [R5] [R6]

   // ----------------------------------------
   // filter bypass
   // ----------------------------------------
   // one bypass for all channels, no per-channel choice
   assign highpassBypass = hpfWord != 24'h000000; // [R1] [R2]

   // ----------------------------------------
   // event sources
   // ----------------------------------------
   wire [14:0] curBit30 = accumBit30;
   // first cycle after reset has no history, so no change is seen
   wire [14:0] bitFlip  = (curBit30 ^ prevBit30) & {15{primed}};

   wire [2:0] selActSign   = accumMode[metering_pkg::ACT_SEL_BIT] ? activeSignFund
                                                                   : activeSignTotal;
   wire [1:0] selReactSign = accumMode[metering_pkg::REACT_SEL_BIT] ? reactiveSignFund
                                                                     : reactiveSignTotal;
   wire [5:0] powerSign    = {selReactSign, pulse1SumSign, selActSign}; // [R14] [R15] [R16]
   wire [5:0] signFlip     = (powerSign ^ prevSign) & {6{primed}};

   wire [11:0] setEvents = {
      signFlip[5:4],                 // [R16]
      signFlip[3],                   // [R15]
      signFlip[2:0],                 // [R14]
      lineCycleMode & lineCycleDone, // [R13]
      |bitFlip[14:12],               // [R12]
      |bitFlip[11:9],                // [R12]
      |bitFlip[8:6],                 // [R12]
      |bitFlip[5:3],                 // [R11]
      |bitFlip[2:0]                  // [R11]
   };

   // set wins over a clear in the same cycle
   wire [11:0] clearMask = (regWrite && hitStatus) ? regWriteData[11:0] : 12'h000;
   assign next_eventFlags = (eventFlags & ~clearMask) | setEvents; // [R18]

   // ----------------------------------------
   // serial word shaping
   // ----------------------------------------
   function automatic logic [31:0] shapeWord(input logic [31:0] v,
                                             input metering_pkg::word_fmt_t f);
      unique case (f)
         metering_pkg::FMT_ZP24:  shapeWord = {8'h00, v[23:0]};      // [R8]
         metering_pkg::FMT_ZP20:  shapeWord = {12'h000, v[19:0]};    // [R8]
         metering_pkg::FMT_SE24:  shapeWord = {{8{v[23]}}, v[23:0]}; // [R9]
         metering_pkg::FMT_ZP10:  shapeWord = {22'h000000, v[9:0]};  // [R10]
         metering_pkg::FMT_RAW32: shapeWord = v;
         metering_pkg::FMT_RAW16: shapeWord = {16'h0000, v[15:0]};
         metering_pkg::FMT_RAW8:  shapeWord = {24'h000000, v[7:0]};
         default:                 shapeWord = 32'h00000000;
      endcase
   endfunction

   function automatic logic [5:0] wordBits(input metering_pkg::word_fmt_t f);
      unique case (f)
         metering_pkg::FMT_ZP10,
         metering_pkg::FMT_RAW16: wordBits = metering_pkg::COMM_BITS_16; // [R10]
         metering_pkg::FMT_RAW8:  wordBits = metering_pkg::COMM_BITS_8;
         default:                 wordBits = metering_pkg::COMM_BITS_32;
      endcase
   endfunction

   // ----------------------------------------
   // read selection
   // ----------------------------------------
   wire [31:0] selValue =
      hitHpf    ? {8'h00, hpfWord} :
      hitCur    ? curPeakWord :
      hitVolt   ? voltPeakWord :
      hitStatus ? {20'h00000, eventFlags} :
      hitSign   ? {26'h0000000, powerSign} :
      hitMode   ? {24'h000000, accumMode} :
      hitWindow ? {24'h000000, peakWindow} :
      extValue;

   wire metering_pkg::word_fmt_t selFmt =
      hitHpf                          ? metering_pkg::FMT_ZP24 :
      (hitCur | hitVolt | hitStatus)  ? metering_pkg::FMT_RAW32 :
      hitSign                         ? metering_pkg::FMT_RAW16 :
      (hitMode | hitWindow)           ? metering_pkg::FMT_RAW8 :
      extFormat;

   wire [31:0] shapedWord = shapeWord(selValue, selFmt);
   wire [5:0]  shapedBits = wordBits(selFmt);

   // ----------------------------------------
   // software registers
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         hpfWord    <= metering_pkg::HPF_RESET;
         accumMode  <= metering_pkg::ACCUM_MODE_RESET;
         peakWindow <= metering_pkg::PEAK_WINDOW_RESET;
      end else if (regWrite) begin
         if (hitHpf)
            hpfWord <= regWriteData[23:0];     // [R2]
         if (hitMode)
            accumMode <= regWriteData[7:0];
         if (hitWindow)
            peakWindow <= regWriteData[7:0];   // [R17]
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         eventFlags <= metering_pkg::EVENT_RESET;
         prevBit30  <= metering_pkg::ACCUM_RESET;
         prevSign   <= metering_pkg::SIGN_RESET;
         primed     <= 1'b0;
      end else begin
         eventFlags <= next_eventFlags;
         prevBit30  <= curBit30;
         prevSign   <= powerSign;
         primed     <= 1'b1;
      end
   end

   // unmapped reads answer zero with readHit low
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         readData  <= 32'h00000000;
         readBits  <= metering_pkg::COMM_BITS_32;
         readHit   <= 1'b0;
         readValid <= 1'b0;
      end else begin
         readValid <= regRead;
         if (regRead) begin
            readData <= anyHit ? shapedWord : 32'h00000000;
            readBits <= anyHit ? shapedBits : metering_pkg::COMM_BITS_32;
            readHit  <= anyHit;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   wire extRead = regRead && !localHit && extHit;

   property p_filter_on;
      regWrite && hitHpf && regWriteData[23:0] == 24'h000000 |=> !highpassBypass;
   endproperty
   a_filter_on: assert property (p_filter_on) else $error("filter not enabled"); // [R1]

   property p_filter_off;
      regWrite && hitHpf && regWriteData[23:0] != 24'h000000 |=> highpassBypass;
   endproperty
   a_filter_off: assert property (p_filter_off) else $error("filter not bypassed"); // [R2]

   property p_peak_top_zero;
      regRead && (hitCur || hitVolt) |=> readData[31:27] == 5'h00 && readBits == 6'h20;
   endproperty
   a_peak_top_zero: assert property (p_peak_top_zero) else $error("peak top bits set"); // [R7]

   property p_cur_tag;
      regRead && hitCur |=> readData[26:24] == $past(curLink.tag);
   endproperty
   a_cur_tag: assert property (p_cur_tag) else $error("current tag mismatch"); // [R4]

   property p_zp24;
      extRead && extFormat == metering_pkg::FMT_ZP24 |=> readData[31:24] == 8'h00
         && readData[23:0] == $past(extValue[23:0]);
   endproperty
   a_zp24: assert property (p_zp24) else $error("zero pad 24 wrong"); // [R8]

   property p_se24;
      extRead && extFormat == metering_pkg::FMT_SE24 |=> readData[31:24] == {8{readData[23]}}
         && readData[23:0] == $past(extValue[23:0]);
   endproperty
   a_se24: assert property (p_se24) else $error("sign extend wrong"); // [R9]

   property p_zp10;
      extRead && extFormat == metering_pkg::FMT_ZP10 |=> readBits == 6'h10
         && readData[31:10] == 22'h000000;
   endproperty
   a_zp10: assert property (p_zp10) else $error("zero pad 10 wrong"); // [R10]

   property p_energy_flag;
      primed && curBit30[5:3] != prevBit30[5:3] |=> eventFlags[1];
   endproperty
   a_energy_flag: assert property (p_energy_flag) else $error("energy flag missed"); // [R11]

   property p_line_cycle;
      lineCycleMode && lineCycleDone |=> eventFlags[5];
   endproperty
   a_line_cycle: assert property (p_line_cycle) else $error("line cycle missed"); // [R13]

   property p_sign_flip;
      primed && powerSign[0] != prevSign[0] |=> eventFlags[6];
   endproperty
   a_sign_flip: assert property (p_sign_flip) else $error("sign flip missed"); // [R14]

   property p_w1c;
      regWrite && hitStatus && regWriteData[0] && !setEvents[0] |=> !eventFlags[0];
   endproperty
   a_w1c: assert property (p_w1c) else $error("flag not cleared"); // [R18]

   property p_hold;
      eventFlags[0] && !(regWrite && hitStatus && regWriteData[0]) |=> eventFlags[0];
   endproperty
   a_hold: assert property (p_hold) else $error("flag dropped"); // [R18]

   property p_cur_value;
      regRead && hitCur |=> readData[23:0] == $past(curLink.value[23:0]);
   endproperty
   a_cur_value: assert property (p_cur_value) else $error("current peak mismatch"); // [R3]

   property p_volt_tag;
      regRead && hitVolt |=> readData[26:24] == $past(voltLink.tag);
   endproperty
   a_volt_tag: assert property (p_volt_tag) else $error("voltage tag mismatch"); // [R6]

   property p_reactive_flag;
      primed && curBit30[8:6] != prevBit30[8:6] |=> eventFlags[2];
   endproperty
   a_reactive_flag: assert property (p_reactive_flag) else $error("reactive missed"); // [R12]

   property p_sum_flip;
      primed && powerSign[3] != prevSign[3] |=> eventFlags[9];
   endproperty
   a_sum_flip: assert property (p_sum_flip) else $error("sum sign flip missed"); // [R15]

   property p_react_flip;
      primed && powerSign[4] != prevSign[4] |=> eventFlags[10];
   endproperty
   a_react_flip: assert property (p_react_flip) else $error("reactive flip missed"); // [R16]

endmodule

// *** design/metering_pkg.sv ***
package metering_pkg;

   // ----------------------------------------
   // register addresses
   // ----------------------------------------
   localparam logic [15:0] ADDR_HPF_DISABLE  = 16'h43b6;
   localparam logic [15:0] ADDR_CURRENT_PEAK = 16'he500;
   localparam logic [15:0] ADDR_VOLTAGE_PEAK = 16'he501;
   localparam logic [15:0] ADDR_EVENT_FLAGS  = 16'he502;
   localparam logic [15:0] ADDR_POWER_SIGN   = 16'he617;
   localparam logic [15:0] ADDR_ACCUM_MODE   = 16'he701;
   localparam logic [15:0] ADDR_PEAK_WINDOW  = 16'he703;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic [23:0] HPF_RESET         = 24'h000000;
   localparam logic [7:0]  ACCUM_MODE_RESET  = 8'h00;
   localparam logic [7:0]  PEAK_WINDOW_RESET = 8'h00;
   localparam logic [11:0] EVENT_RESET       = 12'h000;
   localparam logic [5:0]  SIGN_RESET        = 6'h00;
   localparam logic [14:0] ACCUM_RESET       = 15'h0000;

   // ----------------------------------------
   // field positions and widths
   // ----------------------------------------
   localparam int PEAK_TAG_LSB   = 24;
   localparam int WINDOW_W       = 8;
   localparam int EVENT_W        = 12;
   localparam int ACT_SEL_BIT    = 6;
   localparam int REACT_SEL_BIT  = 7;
   localparam int EV_LINE_CYCLE  = 5;
   localparam int EV_ACT_FLIP_A  = 6;
   localparam int EV_SUM1_FLIP   = 9;
   localparam int EV_REACT_FLIP  = 10;

   // ----------------------------------------
   // serial word formats and lengths
   // ----------------------------------------
   typedef enum logic [2:0] {
      FMT_ZP24  = 3'h0,
      FMT_ZP20  = 3'h1,
      FMT_SE24  = 3'h2,
      FMT_ZP10  = 3'h3,
      FMT_RAW32 = 3'h4,
      FMT_RAW16 = 3'h5,
      FMT_RAW8  = 3'h6
   } word_fmt_t;

   localparam logic [5:0] COMM_BITS_32 = 6'h20;
   localparam logic [5:0] COMM_BITS_16 = 6'h10;
   localparam logic [5:0] COMM_BITS_8  = 6'h08;

endpackage

// *** design/peak_capture_unit.sv ***
module peak_capture_unit #(
   parameter int W = 24
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // samples in, captured peak out
   peak_if.unit      link
);

   logic [W-1:0]                      runMax;
   logic [2:0]                        runTag;
   logic [metering_pkg::WINDOW_W-1:0] halfCount;
   logic [W-1:0]                      value;
   logic [2:0]                        tag;

   // ----------------------------------------
   // largest phase of this sample
   // ----------------------------------------
   // ties go to the lower phase so the tag stays one-hot
   wire          aBest   = link.mag[0] >= link.mag[1] && link.mag[0] >= link.mag[2];
   wire          bBest   = !aBest && link.mag[1] >= link.mag[2];
   wire [W-1:0]  sampMax = aBest ? link.mag[0] : (bBest ? link.mag[1] : link.mag[2]);
   wire [2:0]    sampTag = {!aBest && !bBest, bBest, aBest};
   wire          beats   = link.sampleValid && sampMax > runMax;
   wire [W-1:0]  candMax = beats ? sampMax : runMax;
   wire [2:0]    candTag = beats ? sampTag : runTag;

   // window of zero is taken as one half cycle
   localparam int WINDOW_W_P1 = metering_pkg::WINDOW_W + 1;
   wire [WINDOW_W_P1-1:0] countUp = {1'b0, halfCount} + WINDOW_W_P1'(1);
   wire          lastHalf  = countUp >= {1'b0, link.windowCycles};
   wire          windowEnd = link.halfCycle && lastHalf;

   // ----------------------------------------
   // running maximum and window counter
   // ----------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         runMax    <= '0;
         runTag    <= 3'h0;
         halfCount <= '0;
      end else if (windowEnd) begin
         runMax    <= '0;
         runTag    <= 3'h0;
         halfCount <= '0;
      end else begin
         runMax    <= candMax;
         runTag    <= candTag;
         halfCount <= link.halfCycle ? countUp[metering_pkg::WINDOW_W-1:0] : halfCount;
      end
   end

   // capture at the end of the programmed window [R17]
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         value <= '0;
         tag   <= 3'h0;
      end else if (windowEnd) begin
         value <= candMax;
         tag   <= candMax != '0 ? candTag : 3'h0;
      end
   end

   assign link.value = value; // [R3] [R5]
   assign link.tag   = tag;   // [R4] [R6]

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   property p_tag_onehot;
      $onehot0(link.tag);
   endproperty
   a_tag_onehot: assert property (p_tag_onehot) else $error("peak tag not one-hot"); // [R4]

   property p_tag_with_value;
      link.value != '0 |-> link.tag != 3'h0;
   endproperty
   a_tag_with_value: assert property (p_tag_with_value) else $error("peak without tag"); // [R6]

   property p_no_early_capture;
      !windowEnd |=> $stable(link.value) && $stable(link.tag);
   endproperty
   a_no_early_capture: assert property (p_no_early_capture) else $error("early capture"); // [R17]

endmodule

// *** design/peak_if.sv ***
interface peak_if #(parameter int W = 24);
   logic                                  sampleValid;
   logic [2:0][W-1:0]                     mag;
   logic                                  halfCycle;
   logic [metering_pkg::WINDOW_W-1:0]     windowCycles;
   logic [W-1:0]                          value;
   logic [2:0]                            tag;

   modport owner (output sampleValid, mag, halfCycle, windowCycles,
                  input  value, tag);
   modport unit  (input  sampleValid, mag, halfCycle, windowCycles,
                  output value, tag);
endinterface

// *** tb/metering_peak_status_regs_bench.sv ***
module metering_peak_status_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;

   `define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
      $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end

   // ----------------------------------------
   // signals and helpers
   // ----------------------------------------
   logic                    clk, rstn, regWrite, regRead, readHit, readValid, extHit;
   logic                    highpassBypass, sampleValid, halfCycle, lineCycleMode;
   logic                    lineCycleDone, pulse1SumSign;
   logic [15:0]             regAddr;
   logic [31:0]             regWriteData, readData, extValue, r, expD;
   logic [5:0]              readBits, expB;
   metering_pkg::word_fmt_t extFormat;
   logic [2:0][23:0]        currentMag, voltageMag;
   logic [4:0][2:0]         accumBit30;
   logic [2:0]              activeSignTotal, activeSignFund;
   logic [1:0]              reactiveSignTotal, reactiveSignFund;
   logic [11:0]             eventFlags, ev;
   logic [23:0]             best [2];
   logic [2:0]              tag [2];
   logic [31:0]             seed = 32'h00000052;
   int                      n_fail = 0;
   int                      compares = 0;

   metering_peak_status_regs #(.DATA_W(24)) metering_peak_status_regs_i (
      .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
      .regWriteData(regWriteData), .readData(readData), .readBits(readBits),
      .readHit(readHit), .readValid(readValid), .extHit(extHit), .extValue(extValue),
      .extFormat(extFormat), .highpassBypass(highpassBypass), .sampleValid(sampleValid),
      .halfCycle(halfCycle), .currentMag(currentMag), .voltageMag(voltageMag),
      .accumBit30(accumBit30), .lineCycleMode(lineCycleMode), .lineCycleDone(lineCycleDone),
      .activeSignTotal(activeSignTotal), .activeSignFund(activeSignFund),
      .reactiveSignTotal(reactiveSignTotal), .reactiveSignFund(reactiveSignFund),
      .pulse1SumSign(pulse1SumSign), .eventFlags(eventFlags));

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction

   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(negedge clk);
      regAddr = a;
      regWriteData = d;
      regWrite = 1'b1;
      @(negedge clk);
      regWrite = 1'b0;
   endtask

   task automatic chkRd(input logic [15:0] a, input logic [31:0] d, input logic [5:0] b);
      @(negedge clk);
      regAddr = a;
      regRead = 1'b1;
      @(negedge clk);
      regRead = 1'b0;
      `CHK(readValid, 1'b1)
      `CHK(readData, d)
      `CHK(readBits, b)
   endtask

   task automatic final_report;
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // slack is generous: the whole sequence needs well under a thousand cycles
   initial begin
      #200000;
      n_fail++;
      final_report();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {rstn, regWrite, regRead, extHit, sampleValid, halfCycle, lineCycleDone} = '0;
      {regAddr, regWriteData, extValue, currentMag, voltageMag, accumBit30} = '0;
      {activeSignTotal, activeSignFund, reactiveSignTotal, reactiveSignFund} = '0;
      {pulse1SumSign, lineCycleMode} = 2'b01;
      extFormat = metering_pkg::FMT_ZP24;
      repeat (20) @(negedge clk);
      rstn = 1'b1;
      chkRd(metering_pkg::ADDR_HPF_DISABLE, 32'h0, 6'h20);
      chkRd(metering_pkg::ADDR_CURRENT_PEAK, 32'h0, 6'h20);
      chkRd(metering_pkg::ADDR_VOLTAGE_PEAK, 32'h0, 6'h20);
      chkRd(metering_pkg::ADDR_EVENT_FLAGS, 32'h0, 6'h20);
      chkRd(metering_pkg::ADDR_PEAK_WINDOW, 32'h0, 6'h08);
      `CHK(readHit, 1'b1)
      chkRd(16'h1234, 32'h0, 6'h20);
      `CHK(readHit, 1'b0)
      `CHK(highpassBypass, 1'b0)
      for (int i = 0; i < 3; i++) begin
         r = rnd();
         expD = 32'h1 << (r[7:0] % 24);
         wr(metering_pkg::ADDR_HPF_DISABLE, {8'hff, expD[23:0]});
         `CHK(highpassBypass, 1'b1)
         chkRd(metering_pkg::ADDR_HPF_DISABLE, expD, 6'h20);
         wr(metering_pkg::ADDR_HPF_DISABLE, 32'h0);
         `CHK(highpassBypass, 1'b0)
      end
      $display("test filter done");
      // window of two half cycles: first pulse must not latch
      wr(metering_pkg::ADDR_PEAK_WINDOW, 32'h2);
      chkRd(metering_pkg::ADDR_PEAK_WINDOW, 32'h2, 6'h08);
      best = '{24'h0, 24'h0};
      tag = '{3'h0, 3'h0};
      for (int k = 0; k < 4; k++) begin
         @(negedge clk);
         sampleValid = 1'b1;
         halfCycle = k[0];
         for (int p = 0; p < 3; p++) begin
            r = rnd();
            currentMag[p] = r[23:0];
            voltageMag[p] = r[31:8];
            if (p == 1 && k == 0) currentMag[1] = currentMag[0];
            if (currentMag[p] > best[0]) begin
               best[0] = currentMag[p];
               tag[0] = 3'h1 << p;
            end
            if (voltageMag[p] > best[1]) begin
               best[1] = voltageMag[p];
               tag[1] = 3'h1 << p;
            end
         end
         @(negedge clk);
         {sampleValid, halfCycle} = 2'b00;
         if (k == 1) chkRd(metering_pkg::ADDR_CURRENT_PEAK, 32'h0, 6'h20);
      end
      wr(metering_pkg::ADDR_CURRENT_PEAK, 32'hffffffff);
      chkRd(metering_pkg::ADDR_CURRENT_PEAK, {5'h0, tag[0], best[0]}, 6'h20);
      chkRd(metering_pkg::ADDR_VOLTAGE_PEAK, {5'h0, tag[1], best[1]}, 6'h20);
      $display("test peak done");
      for (int i = 0; i < 12; i++) begin
         @(negedge clk);
         if (i < 5) accumBit30[i][i % 3] = ~accumBit30[i][i % 3];
         else if (i == 5) lineCycleDone = 1'b1;
         else if (i < 9) activeSignTotal[i-6] = ~activeSignTotal[i-6];
         else if (i == 9) pulse1SumSign = ~pulse1SumSign;
         else reactiveSignTotal[i-10] = ~reactiveSignTotal[i-10];
         @(negedge clk);
         lineCycleDone = 1'b0;
         repeat (2) @(negedge clk);
         ev = 12'h001 << i;
         `CHK(eventFlags, ev)
         chkRd(metering_pkg::ADDR_EVENT_FLAGS, {20'h0, ev}, 6'h20);
         wr(metering_pkg::ADDR_EVENT_FLAGS, {20'h0, ~ev});
         @(negedge clk);
         `CHK(eventFlags, ev)
         wr(metering_pkg::ADDR_EVENT_FLAGS, {20'h0, ev});
         @(negedge clk);
         `CHK(eventFlags, 12'h000)
      end
      chkRd(metering_pkg::ADDR_POWER_SIGN, 32'h0000003f, 6'h10);
      // switch to fundamental sources with equal values so the switch itself is quiet
      // done pulse outside line-cycle mode must stay quiet too
      @(negedge clk);
      activeSignFund = activeSignTotal;
      reactiveSignFund = reactiveSignTotal;
      {lineCycleMode, lineCycleDone} = 2'b01;
      wr(metering_pkg::ADDR_ACCUM_MODE, 32'h000000c0);
      {activeSignTotal, reactiveSignTotal, lineCycleDone} = 6'h00;
      repeat (3) @(negedge clk);
      `CHK(eventFlags, 12'h000)
      activeSignFund[2] = 1'b0;
      reactiveSignFund[1] = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(eventFlags, 12'h900)
      chkRd(metering_pkg::ADDR_ACCUM_MODE, 32'h000000c0, 6'h08);
      chkRd(metering_pkg::ADDR_POWER_SIGN, 32'h0000001b, 6'h10);
      $display("test events done");
      extHit = 1'b1;
      for (int f = 0; f < 8; f++) begin
         r = rnd();
         if (f == 2) r[23] = 1'b1;
         extValue = r;
         extFormat = metering_pkg::word_fmt_t'(f);
         case (f)
            0: {expD, expB} = {8'h0, r[23:0], 6'h20};
            1: {expD, expB} = {12'h0, r[19:0], 6'h20};
            2: {expD, expB} = {{8{r[23]}}, r[23:0], 6'h20};
            3: {expD, expB} = {22'h0, r[9:0], 6'h10};
            4: {expD, expB} = {r, 6'h20};
            5: {expD, expB} = {16'h0, r[15:0], 6'h10};
            6: {expD, expB} = {24'h0, r[7:0], 6'h08};
            default: {expD, expB} = {32'h0, 6'h20};
         endcase
         chkRd(16'h1234, expD, expB);
         `CHK(readHit, 1'b1)
      end
      $display("test formats done");
      final_report();
   end
endmodule
